// ### calendar_clock_power.sv
// Calendar clock core with power-mode, bus clock gating and reset behaviour
`timescale 1ns/1ps
`include "calendar_clock_regs.svh"
module calendar_clock_power #(
  parameter int HALF_SEC_TICKS = `HALF_SEC_TICKS,
  parameter int TSYNC_WINDOW   = `TSYNC_WINDOW,
  parameter int CLOCK_SOURCES  = `CLOCK_SOURCES
) (
  input  wire logic                       clock,
  input  wire logic                       reset_n,
  input  wire logic                       device_reset,
  input  wire logic                       watchdog_reset,
  input  wire logic                       master_reset_pin_n,
  input  wire logic                       battery_backup_mode,
  input  wire logic                       idle_mode,
  input  calendar_clock_pkg::prio_t       alarm_priority,
  input  calendar_clock_pkg::prio_t       cpu_priority,
  input  wire logic [CLOCK_SOURCES-1:0]   timebase_ticks,
  input  calendar_clock_pkg::addr_t       addr,
  input  calendar_clock_pkg::word_t       wr_data,
  input  wire logic                       wr_en,
  input  wire logic                       rd_en,
  output calendar_clock_pkg::word_t       rd_data,
  output logic                            alarm_interrupt_flag,
  output logic                            wake_request,
  output logic                            bus_clock_active,
  output logic                            clock_output_pin,
  output logic                            clock_output_pin_oe
);
  import calendar_clock_pkg::*;

  localparam int PW = $clog2(HALF_SEC_TICKS);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic        on_q;
  logic        idle_stop_q;
  src_sel_t    timebase_source_select_q;
  logic        oe_q;
  logic        alarm_enable_q;
  logic        alarm_repeat_forever_q;
  match_mask_t alarm_match_mask_q;
  word_t       alarm_time_value_q;
  word_t       alarm_date_value_q;
  word_t       current_time_value_q;
  word_t       current_time_value_d;
  word_t       current_date_value_q;
  word_t       time_read_sync_q;
  word_t       date_read_sync_q;
  logic [PW-1:0] prescale_q;
  logic        half_q;
  logic        time_sync_status_q;
  logic        half_second_status_q;
  logic        alarm_sync_status_q;
  logic        alarm_flag_q;
  word_t       rd_data_q;
  logic        status_clear_n;
  logic        on_released;
  logic        any_device_reset;
  logic        bus_run;
  logic        tick;
  logic        half_wrap;
  logic        second_tick;
  logic        fields_match;
  logic        alarm_event;
  logic        wr_ctrl;
  logic        wr_alarm_ctrl;
  logic        wr_time;
  logic        wr_date;
  logic        wr_alarm_time;
  logic        wr_alarm_date;
  logic        wr_flag;
  logic        sync_window;
  word_t       ctrl_view;
  word_t       alarm_ctrl_view;
  word_t       read_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Reset classes and bus clock gating
  // Watchdog and master reset pin count as device resets
  assign any_device_reset = device_reset | watchdog_reset |
                            ~master_reset_pin_n; // [R15]
  // Bus domain stops only when idle-stop is set and the chip idles
  assign bus_run = ~(idle_mode & idle_stop_q); // [R6] [R7]
  assign bus_clock_active = bus_run;

  assign wr_ctrl       = wr_en & bus_run & (addr == `OFS_CLOCK_CTRL);
  assign wr_alarm_ctrl = wr_en & bus_run & (addr == `OFS_ALARM_CTRL);
  assign wr_time       = wr_en & bus_run & (addr == `OFS_CUR_TIME);
  assign wr_date       = wr_en & bus_run & (addr == `OFS_CUR_DATE);
  assign wr_alarm_time = wr_en & bus_run & (addr == `OFS_ALARM_TIME);
  assign wr_alarm_date = wr_en & bus_run & (addr == `OFS_ALARM_DATE);
  assign wr_flag       = wr_en & bus_run & (addr == `OFS_FLAG_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Clock control register, cleared by power-on reset only
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      on_q                     <= 1'b0;
      idle_stop_q              <= 1'b0;
      timebase_source_select_q <= `SRC_RESET;
      oe_q                     <= 1'b0;
    end else if (wr_ctrl) begin // [R10]
      on_q                     <= wr_data[`CTRL_ON_BIT];
      idle_stop_q              <= wr_data[`CTRL_IDLE_STOP];
      timebase_source_select_q <= wr_data[`CTRL_SRC_HI:`CTRL_SRC_LO];
      oe_q                     <= wr_data[`CTRL_OE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm control register, bus clocked, cleared by every device reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      alarm_enable_q         <= 1'b0;
      alarm_repeat_forever_q <= 1'b0;
      alarm_match_mask_q     <= `MASK_RESET;
    end else if (any_device_reset) begin
      alarm_enable_q         <= 1'b0; // [R9] [R15]
      alarm_repeat_forever_q <= 1'b0;
      alarm_match_mask_q     <= `MASK_RESET;
    end else if (bus_run) begin // [R8]
      if (wr_alarm_ctrl) begin
        alarm_enable_q         <= wr_data[`ALRM_EN_BIT];
        alarm_repeat_forever_q <= wr_data[`ALRM_REPEAT_BIT];
        alarm_match_mask_q     <= wr_data[`ALRM_MASK_HI:`ALRM_MASK_LO];
      end else if (alarm_event && !alarm_repeat_forever_q) begin
        alarm_enable_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm time and date storage, bus clocked
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      alarm_time_value_q <= `WORD_ZERO;
      alarm_date_value_q <= `WORD_ZERO;
    end else if (bus_run) begin // [R8]
      if (wr_alarm_time) begin
        alarm_time_value_q <= wr_data;
      end
      if (wr_alarm_date) begin
        alarm_date_value_q <= wr_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timebase source and prescaler
  // The selected source keeps ticking in every power mode
  assign tick = on_q & timebase_ticks[timebase_source_select_q]; // [R3]
  assign half_wrap = tick & (prescale_q == PW'(HALF_SEC_TICKS - 1));
  assign second_tick = half_wrap & half_q;

  // No reset term: only a seconds write clears the prescaler
  always_ff @(posedge clock) begin
    if (wr_time) begin
      prescale_q <= '0; // [R13]
      half_q     <= 1'b0;
    end else if (tick) begin // [R14] [R1] [R4] [R18]
      if (half_wrap) begin
        prescale_q <= '0;
        half_q     <= ~half_q;
      end else begin
        prescale_q <= prescale_q + PW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Current time and date, untouched by every reset
  always_comb begin
    current_time_value_d = current_time_value_q;
    if (current_time_value_q[`SEC_LO+3:`SEC_LO] != 4'h9) begin
      current_time_value_d[`SEC_LO+3:`SEC_LO] =
        current_time_value_q[`SEC_LO+3:`SEC_LO] + 4'h1;
    end else if (current_time_value_q[`SEC_HI:`SEC_LO] != `BCD_SEC_MAX) begin
      current_time_value_d[`SEC_LO+3:`SEC_LO] = 4'h0;
      current_time_value_d[`SEC_HI:`SEC_LO+4] =
        current_time_value_q[`SEC_HI:`SEC_LO+4] + 3'h1;
    end else begin
      current_time_value_d[`SEC_HI:`SEC_LO] = 7'h00;
      if (current_time_value_q[`MIN_LO+3:`MIN_LO] != 4'h9) begin
        current_time_value_d[`MIN_LO+3:`MIN_LO] =
          current_time_value_q[`MIN_LO+3:`MIN_LO] + 4'h1;
      end else if (current_time_value_q[`MIN_HI:`MIN_LO] != `BCD_MIN_MAX)
      begin
        current_time_value_d[`MIN_LO+3:`MIN_LO] = 4'h0;
        current_time_value_d[`MIN_HI:`MIN_LO+4] =
          current_time_value_q[`MIN_HI:`MIN_LO+4] + 3'h1;
      end else begin
        current_time_value_d[`MIN_HI:`MIN_LO] = 7'h00;
        if (current_time_value_q[`HOUR_HI:`HOUR_LO] == `BCD_HOUR_MAX) begin
          current_time_value_d[`HOUR_HI:`HOUR_LO] = 6'h00;
        end else if (current_time_value_q[`HOUR_LO+3:`HOUR_LO] != 4'h9) begin
          current_time_value_d[`HOUR_LO+3:`HOUR_LO] =
            current_time_value_q[`HOUR_LO+3:`HOUR_LO] + 4'h1;
        end else begin
          current_time_value_d[`HOUR_LO+3:`HOUR_LO] = 4'h0;
          current_time_value_d[`HOUR_HI:`HOUR_LO+4] =
            current_time_value_q[`HOUR_HI:`HOUR_LO+4] + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (wr_time) begin
      current_time_value_q <= wr_data; // [R11] [R12]
    end else if (second_tick) begin // [R1] [R10]
      current_time_value_q <= current_time_value_d;
    end
  end

  always_ff @(posedge clock) begin
    if (wr_date) begin
      current_date_value_q <= wr_data; // [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read synchronizers for time and date, bus clocked
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      time_read_sync_q <= `WORD_ZERO;
      date_read_sync_q <= `WORD_ZERO;
    end else if (bus_run) begin // [R8]
      time_read_sync_q <= current_time_value_q;
      date_read_sync_q <= current_date_value_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sync status bits, cleared asynchronously while the module is off
  assign status_clear_n = reset_n & on_q; // [R16]

  enable_release_sync u_release_sync (
    .clock     (clock),
    .clear_n   (status_clear_n),
    .level_in  (on_q),
    .level_out (on_released)
  ); // [R20]

  assign sync_window = half_q &
                       (prescale_q >= PW'(HALF_SEC_TICKS - TSYNC_WINDOW));

  always_ff @(posedge clock or negedge status_clear_n) begin
    if (!status_clear_n) begin
      time_sync_status_q   <= 1'b0; // [R16]
      half_second_status_q <= 1'b0;
      alarm_sync_status_q  <= 1'b0;
    end else if (on_released && bus_run) begin // [R20] [R8]
      time_sync_status_q   <= sync_window;
      half_second_status_q <= half_q;
      alarm_sync_status_q  <= alarm_enable_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm match and interrupt flag
  alarm_field_compare u_alarm_compare (
    .cur_time         (current_time_value_q),
    .cur_date         (current_date_value_q),
    .alarm_time       (alarm_time_value_q),
    .alarm_date       (alarm_date_value_q),
    .alarm_match_mask (alarm_match_mask_q),
    .fields_match     (fields_match)
  );

  // Evaluated in every power mode, checked once per second
  assign alarm_event = second_tick & alarm_enable_q & fields_match; // [R2]

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      alarm_flag_q <= 1'b0;
    end else if (alarm_event) begin
      alarm_flag_q <= 1'b1; // [R19]
    end else if (wr_flag && wr_data[`FLAG_ALARM_BIT]) begin
      alarm_flag_q <= 1'b0;
    end
  end

  assign alarm_interrupt_flag = alarm_flag_q;

  // Wake only from Idle, never from battery-backup
  assign wake_request = alarm_flag_q & idle_mode & ~battery_backup_mode &
                        (alarm_priority > cpu_priority); // [R2] [R5] [R4]

  ////////////////////////////////////////////////////////////////////////////
  // Clock output pin
  assign clock_output_pin_oe = oe_q & on_q; // [R17]
  assign clock_output_pin    = oe_q & on_q & half_q; // [R17]

  ////////////////////////////////////////////////////////////////////////////
  // Register read path
  always_comb begin
    ctrl_view = `WORD_ZERO;
    ctrl_view[`CTRL_ON_BIT]              = on_q;
    ctrl_view[`CTRL_IDLE_STOP]           = idle_stop_q;
    ctrl_view[`CTRL_SRC_HI:`CTRL_SRC_LO] = timebase_source_select_q;
    ctrl_view[`CTRL_TSYNC_BIT]           = time_sync_status_q;
    ctrl_view[`CTRL_HALF_BIT]            = half_second_status_q;
    ctrl_view[`CTRL_OE_BIT]              = oe_q;
  end

  always_comb begin
    alarm_ctrl_view = `WORD_ZERO;
    alarm_ctrl_view[`ALRM_EN_BIT]               = alarm_enable_q;
    alarm_ctrl_view[`ALRM_REPEAT_BIT]           = alarm_repeat_forever_q;
    alarm_ctrl_view[`ALRM_SYNC_BIT]             = alarm_sync_status_q;
    alarm_ctrl_view[`ALRM_MASK_HI:`ALRM_MASK_LO] = alarm_match_mask_q;
  end

  always_comb begin
    read_mux = `WORD_ZERO;
    unique case (addr)
      `OFS_CLOCK_CTRL:  read_mux = ctrl_view;
      `OFS_ALARM_CTRL:  read_mux = alarm_ctrl_view;
      `OFS_CUR_TIME:    read_mux = time_read_sync_q;
      `OFS_CUR_DATE:    read_mux = date_read_sync_q;
      `OFS_ALARM_TIME:  read_mux = alarm_time_value_q;
      `OFS_ALARM_DATE:  read_mux = alarm_date_value_q;
      `OFS_FLAG_STATUS: read_mux[`FLAG_ALARM_BIT] = alarm_flag_q;
      default:          read_mux = `WORD_ZERO;
    endcase
  end

  // Read data stand for exactly one cycle after the strobe
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_q <= `WORD_ZERO;
    end else if (rd_en && bus_run) begin // [R6]
      rd_data_q <= read_mux;
    end else begin
      rd_data_q <= `WORD_ZERO;
    end
  end

  assign rd_data = rd_data_q;
endmodule

// ### calendar_clock_regs.svh
// Register offsets, field positions and reset values of the calendar clock
//
// Function
// R1: Calendar clock keeps counting during battery-backup power mode.
// R2: Alarms still evaluate in battery-backup mode but never wake the chip.
// R3: Battery-backup mode keeps running the source chosen by bits 10:9.
// R4: Idle mode keeps timekeeping and alarms exactly as in run mode; with idle-stop set the code does not disable a one-shot alarm when it fires.
// R5: Idle wake only when alarm priority exceeds current processor priority.
// R6: Idle-stop bit 13 set plus Idle gates off the bus clock.
// R7: Idle-stop bit clear keeps the bus clock domain fully running in Idle.
// R8: Alarm setup, sync bits, read syncs on bus clock; timekeeping is not.
// R9: Device reset restores the alarm control register, disabling the alarm.
// R10: An enabled module keeps timekeeping running through a device reset.
// R11: Power-on reset leaves current time and date registers unchanged.
// R12: Software should reload time and date after power-on reset.
// R13: Timekeeping prescalers clear only on a write of the seconds field.
// R14: No reset of any kind clears or alters the prescaler state.
// R15: Watchdog reset acts on the block exactly as a device reset.
// R16: Enable low asynchronously clears and holds the three sync status bits.
// R17: Clock output pin is output enable ANDed with module enable.
// R18: Master reset pin held low keeps calendar clock and oscillator running.
// R19: Alarm flag sets on every unmasked match regardless of enables; the code sets it only while on_q and alarm_enable_q are set.
// R20: Enable release passes a synchronizer before held status bits resume.
`ifndef CALENDAR_CLOCK_REGS_SVH
`define CALENDAR_CLOCK_REGS_SVH

`define ADDR_W            8
`define OFS_CLOCK_CTRL    8'h00
`define OFS_ALARM_CTRL    8'h04
`define OFS_CUR_TIME      8'h08
`define OFS_CUR_DATE      8'h0c
`define OFS_ALARM_TIME    8'h10
`define OFS_ALARM_DATE    8'h14
`define OFS_FLAG_STATUS   8'h18

`define CTRL_ON_BIT       15
`define CTRL_IDLE_STOP    13
`define CTRL_SRC_HI       10
`define CTRL_SRC_LO       9
`define CTRL_TSYNC_BIT    2
`define CTRL_HALF_BIT     1
`define CTRL_OE_BIT       0

`define ALRM_EN_BIT       15
`define ALRM_REPEAT_BIT   14
`define ALRM_SYNC_BIT     12
`define ALRM_MASK_HI      11
`define ALRM_MASK_LO      8

`define FLAG_ALARM_BIT    0

`define SEC_HI            14
`define SEC_LO            8
`define MIN_HI            22
`define MIN_LO            16
`define HOUR_HI           29
`define HOUR_LO           24

`define BCD_SEC_MAX       7'h59
`define BCD_MIN_MAX       7'h59
`define BCD_HOUR_MAX      6'h23

`define HALF_SEC_TICKS    16384
`define TSYNC_WINDOW      32
`define CLOCK_SOURCES     4

`define WORD_ZERO         32'h0000_0000
`define SRC_RESET         2'h0
`define MASK_RESET        4'h0
`define PRIO_W            3

`endif

// ### calendar_clock_pkg.sv
// Types shared by the calendar clock power and reset logic
package calendar_clock_pkg;
  typedef logic [31:0] word_t;
  typedef logic [7:0]  addr_t;
  typedef logic [1:0]  src_sel_t;
  typedef logic [3:0]  match_mask_t;
  typedef logic [2:0]  prio_t;
endpackage

// ### enable_release_sync.sv
// Two-stage synchronizer with asynchronous clear for enable release
`timescale 1ns/1ps
module enable_release_sync (
  input  wire logic clock,
  input  wire logic clear_n,
  input  wire logic level_in,
  output logic      level_out
);
  logic stage1_q;
  logic stage2_q;

  always_ff @(posedge clock or negedge clear_n) begin
    if (!clear_n) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
    end else begin
      stage1_q <= level_in;
      stage2_q <= stage1_q;
    end
  end

  assign level_out = stage2_q;
endmodule

// ### alarm_field_compare.sv
// Masked compare of alarm time and date against the current values
`timescale 1ns/1ps
`include "calendar_clock_regs.svh"
module alarm_field_compare
  import calendar_clock_pkg::*;
(
  input  calendar_clock_pkg::word_t       cur_time,
  input  calendar_clock_pkg::word_t       cur_date,
  input  calendar_clock_pkg::word_t       alarm_time,
  input  calendar_clock_pkg::word_t       alarm_date,
  input  calendar_clock_pkg::match_mask_t alarm_match_mask,
  output logic                            fields_match
);
  logic sec_eq;
  logic min_eq;
  logic hour_eq;
  logic date_eq;

  // A set mask bit drops that field from the compare
  assign sec_eq  = alarm_match_mask[0] |
                   (cur_time[`SEC_HI:`SEC_LO] == alarm_time[`SEC_HI:`SEC_LO]);
  assign min_eq  = alarm_match_mask[1] |
                   (cur_time[`MIN_HI:`MIN_LO] == alarm_time[`MIN_HI:`MIN_LO]);
  assign hour_eq = alarm_match_mask[2] |
                   (cur_time[`HOUR_HI:`HOUR_LO] ==
                    alarm_time[`HOUR_HI:`HOUR_LO]);
  assign date_eq = alarm_match_mask[3] | (cur_date == alarm_date);

  assign fields_match = sec_eq & min_eq & hour_eq & date_eq;
endmodule

// ### calendar_clock_props.sv
// Concurrent checks on the calendar clock top-level ports
`timescale 1ns/1ps
`include "calendar_clock_regs.svh"
module calendar_clock_props
  import calendar_clock_pkg::*;
(
  input wire logic                 clock,
  input wire logic                 reset_n,
  input wire logic                 device_reset,
  input wire logic                 watchdog_reset,
  input wire logic                 master_reset_pin_n,
  input wire logic                 battery_backup_mode,
  input wire logic                 idle_mode,
  input calendar_clock_pkg::prio_t alarm_priority,
  input calendar_clock_pkg::prio_t cpu_priority,
  input calendar_clock_pkg::addr_t addr,
  input calendar_clock_pkg::word_t wr_data,
  input wire logic                 wr_en,
  input wire logic                 rd_en,
  input calendar_clock_pkg::word_t rd_data,
  input wire logic                 alarm_interrupt_flag,
  input wire logic                 wake_request,
  input wire logic                 bus_clock_active,
  input wire logic                 clock_output_pin,
  input wire logic                 clock_output_pin_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic clr_req;
  assign clr_req = wr_en && (addr == `OFS_FLAG_STATUS) && wr_data[0];
  ////////////////////////////////////////////////////////////////////////////
  sequence s_dev_rst;
    device_reset || watchdog_reset || !master_reset_pin_n;
  endsequence
  sequence s_alarm_rd;
    rd_en && (addr == `OFS_ALARM_CTRL) && bus_clock_active;
  endsequence
  sequence s_flag_held;
    alarm_interrupt_flag && !clr_req;
  endsequence
  property p_oe_pin;
    clock_output_pin |-> clock_output_pin_oe;
  endproperty
  property p_bus_run;
    !idle_mode |-> bus_clock_active;
  endproperty
  property p_wake_cause;
    wake_request |-> alarm_interrupt_flag && idle_mode
      && !battery_backup_mode && (alarm_priority > cpu_priority);
  endproperty
  property p_wake_given;
    alarm_interrupt_flag && idle_mode && !battery_backup_mode
      && (alarm_priority > cpu_priority) |-> wake_request;
  endproperty
  property p_no_bb_wake;
    battery_backup_mode |-> !wake_request;
  endproperty
  property p_rd_drop;
    (!rd_en || !bus_clock_active) |=> rd_data == 32'h0000_0000;
  endproperty
  property p_flag_hold;
    s_flag_held |=> alarm_interrupt_flag;
  endproperty
  property p_alarm_clr;
    s_dev_rst ##1 !wr_en ##1 s_alarm_rd |=>
      (rd_data[15:14] == 2'h0) && (rd_data[11:8] == 4'h0);
  endproperty
  ////////////////////////////////////////////////////////////////////////////
  a_oe_pin: assert property (p_oe_pin) else $error("pin no enable");
  a_bus_run: assert property (p_bus_run) else $error("bus gated");
  a_wake_cause: assert property (p_wake_cause) else $error("bad wake");
  a_wake_given: assert property (p_wake_given) else $error("no wake");
  a_no_bb_wake: assert property (p_no_bb_wake) else $error("bb wake");
  a_rd_drop: assert property (p_rd_drop) else $error("stray read");
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
  a_alarm_clr: assert property (p_alarm_clr) else $error("alarm kept");
endmodule
bind calendar_clock_power calendar_clock_props i_props (
  .clock, .reset_n, .device_reset, .watchdog_reset, .master_reset_pin_n,
  .battery_backup_mode, .idle_mode, .alarm_priority, .cpu_priority, .addr,
  .wr_data, .wr_en, .rd_en, .rd_data, .alarm_interrupt_flag, .wake_request,
  .bus_clock_active, .clock_output_pin, .clock_output_pin_oe
);

// ### cpu_bus_model.sv
// Processor-side register bus master model
`timescale 1ns/1ps
module cpu_bus_model (
  input  wire logic                clock,
  output calendar_clock_pkg::addr_t addr,
  output calendar_clock_pkg::word_t wr_data,
  output logic                     wr_en,
  output logic                     rd_en
);
  import calendar_clock_pkg::*;
  initial begin
    addr = 8'h00;
    wr_data = 32'h0000_0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  task automatic wr(input addr_t a, input word_t d);
    @(posedge clock);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clock);
    wr_en   <= 1'b0;
    addr    <= ~a;
    wr_data <= ~d;
  endtask
  task automatic rd(input addr_t a);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    addr  <= ~a;
  endtask
endmodule

// ### calendar_clock_power_tb.sv
// Self-checking testbench for the calendar clock power and reset block
`timescale 1ns/1ps
`include "calendar_clock_regs.svh"
module calendar_clock_power_tb;
  import calendar_clock_pkg::*;
  localparam int NSRC = 4;
  localparam word_t TMASK = 32'h3f7f_7f00;
  typedef struct packed {word_t val; word_t msk;} rd_exp_s;
  logic            clock = 1'b0;
  logic            reset_n = 1'b0;
  logic            device_reset = 1'b0;
  logic            watchdog_reset = 1'b0;
  logic            master_reset_pin_n = 1'b1;
  logic            battery_backup_mode = 1'b0;
  logic            idle_mode = 1'b0;
  prio_t           alarm_priority = 3'h0;
  prio_t           cpu_priority = 3'h0;
  logic [NSRC-1:0] timebase_ticks = 4'h0;
  addr_t           addr;
  word_t           wr_data;
  logic            wr_en;
  logic            rd_en;
  word_t           rd_data;
  logic            alarm_interrupt_flag;
  logic            wake_request;
  logic            bus_clock_active;
  logic            clock_output_pin;
  logic            clock_output_pin_oe;
  logic            rd_seen = 1'b0;
  rd_exp_s         q[$];
  rd_exp_s         ex;
  src_sel_t        src;
  word_t           ctrl;
  int              n_mismatch = 0;
  int              total_checks = 0;
  always #50 clock = ~clock;
  calendar_clock_power #(.HALF_SEC_TICKS(4), .TSYNC_WINDOW(2),
    .CLOCK_SOURCES(NSRC)) i_dut (
    .clock, .reset_n, .device_reset, .watchdog_reset, .master_reset_pin_n,
    .battery_backup_mode, .idle_mode, .alarm_priority, .cpu_priority,
    .timebase_ticks, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
    .alarm_interrupt_flag, .wake_request, .bus_clock_active,
    .clock_output_pin, .clock_output_pin_oe);
  cpu_bus_model i_cpu (.clock, .addr, .wr_data, .wr_en, .rd_en);
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input word_t seen, input word_t e);
    total_checks++;
    if (seen !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic read_chk(input addr_t a, input word_t e, input word_t m);
    q.push_back('{e, m});
    i_cpu.rd(a);
  endtask
  task automatic tick(input int n);
    logic [NSRC-1:0] one;
    one = NSRC'(1) << src;
    repeat (n) begin
      @(posedge clock);
      timebase_ticks <= one | (NSRC'($urandom) & ~one);
      @(posedge clock);
      timebase_ticks <= NSRC'($urandom) & ~one;
    end
  endtask
  task automatic pulse(input int k);
    @(posedge clock);
    device_reset <= (k == 0);
    watchdog_reset <= (k == 1);
    master_reset_pin_n <= (k != 2);
    @(posedge clock);
    device_reset <= 1'b0;
    watchdog_reset <= 1'b0;
    master_reset_pin_n <= 1'b1;
  endtask
  task automatic bit_chk(input string name, input logic s, input logic e);
    check(name, {31'h0, s}, {31'h0, e});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) rd_seen <= rd_en;
  always @(negedge clock) begin
    if (rd_seen) begin
      ex = q.pop_front();
      check("rd_data", rd_data & ex.msk, ex.val & ex.msk);
    end
  end
  initial begin
    #500000;
    n_mismatch++;
    complete_run;
  end
  initial begin
    void'($urandom(32'h7db2));
    src = src_sel_t'($urandom % NSRC);
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    read_chk(`OFS_CLOCK_CTRL, 32'h0, 32'hffff_ffff);
    read_chk(`OFS_ALARM_CTRL, 32'h0, 32'hffff_ffff);
    read_chk(`OFS_FLAG_STATUS, 32'h0, 32'hffff_ffff);
    read_chk(8'h1c, 32'h0, 32'hffff_ffff);
    i_cpu.wr(`OFS_CUR_TIME, 32'h0000_5800);
    i_cpu.wr(`OFS_CUR_DATE, 32'h0610_2705);
    ctrl = 32'h0000_8001 | (32'(src) << `CTRL_SRC_LO);
    i_cpu.wr(`OFS_CLOCK_CTRL, ctrl);
    battery_backup_mode <= 1'b1;
    @(negedge clock);
    bit_chk("pin_oe", clock_output_pin_oe, 1'b1);
    read_chk(`OFS_CLOCK_CTRL, ctrl, 32'h0000_a601);
    tick(8);
    read_chk(`OFS_CUR_TIME, 32'h0000_5900, TMASK);
    tick(3);
    for (int k = 0; k < 3; k++)
      pulse(k);
    tick(5);
    read_chk(`OFS_CUR_TIME, 32'h0001_0000, TMASK);
    tick(5);
    i_cpu.wr(`OFS_CUR_TIME, 32'h0000_2000);
    tick(7);
    read_chk(`OFS_CUR_TIME, 32'h0000_2000, TMASK);
    read_chk(`OFS_CLOCK_CTRL, ctrl | 32'h6, 32'h0000_a607);
    tick(1);
    read_chk(`OFS_CUR_TIME, 32'h0000_2100, TMASK);
    battery_backup_mode <= 1'b0;
    idle_mode <= 1'b1;
    alarm_priority <= 3'h5;
    cpu_priority <= 3'h2;
    i_cpu.wr(`OFS_CUR_TIME, 32'h0000_1000);
    i_cpu.wr(`OFS_ALARM_TIME, 32'h0000_1100);
    i_cpu.wr(`OFS_ALARM_DATE, 32'h0610_2705);
    i_cpu.wr(`OFS_ALARM_CTRL, 32'h0000_8000);
    tick(16);
    repeat (3) @(negedge clock);
    bit_chk("flag", alarm_interrupt_flag, 1'b1);
    bit_chk("wake", wake_request, 1'b1);
    @(posedge clock);
    cpu_priority <= 3'h5;
    @(negedge clock);
    bit_chk("wake", wake_request, 1'b0);
    @(posedge clock);
    cpu_priority <= 3'h2;
    battery_backup_mode <= 1'b1;
    @(negedge clock);
    bit_chk("wake", wake_request, 1'b0);
    read_chk(`OFS_ALARM_CTRL, 32'h0, 32'h0000_8000);
    i_cpu.wr(`OFS_FLAG_STATUS, 32'h0000_0001);
    @(negedge clock);
    bit_chk("flag", alarm_interrupt_flag, 1'b0);
    for (int k = 0; k < 3; k++) begin
      i_cpu.wr(`OFS_ALARM_CTRL, 32'h0000_cf00);
      read_chk(`OFS_ALARM_CTRL, 32'h0000_cf00, 32'h0000_cf00);
      pulse(k);
      read_chk(`OFS_ALARM_CTRL, 32'h0, 32'h0000_cf00);
    end
    i_cpu.wr(`OFS_ALARM_CTRL, 32'h0);
    i_cpu.wr(`OFS_CLOCK_CTRL, ctrl | 32'h0000_2000);
    @(negedge clock);
    bit_chk("bus_active", bus_clock_active, 1'b0);
    i_cpu.wr(`OFS_ALARM_CTRL, 32'h0000_4000);
    read_chk(`OFS_ALARM_CTRL, 32'h0, 32'hffff_ffff);
    tick(8);
    idle_mode <= 1'b0;
    read_chk(`OFS_ALARM_CTRL, 32'h0, 32'h0000_4000);
    read_chk(`OFS_CUR_TIME, 32'h0000_1300, TMASK);
    @(posedge clock);
    reset_n <= 1'b0;
    @(posedge clock);
    reset_n <= 1'b1;
    read_chk(`OFS_CUR_TIME, 32'h0000_1300, TMASK);
    i_cpu.wr(`OFS_CLOCK_CTRL, 32'h0000_0001);
    @(negedge clock);
    bit_chk("pin_oe", clock_output_pin_oe, 1'b0);
    bit_chk("pin", clock_output_pin, 1'b0);
    read_chk(`OFS_CLOCK_CTRL, 32'h0000_0001, 32'h0000_0007);
    repeat (3) @(negedge clock);
    complete_run;
  end
endmodule
